//--- hdl/fbio_pkg.sv
// fbio_pkg: constants for the five-pin io port with chip-select and refresh functions.
// assumes a 16-bit register address bus and a 3-bit operating mode input.
package fbio_pkg;
  localparam int FBIO_PINS = 5;
  localparam logic [15:0] FBIO_DIR_ADDR = 16'hFFCD;
  localparam logic [15:0] FBIO_DATA_ADDR = 16'hFFCF;
  localparam logic [7:0] FBIO_DIR_RST_LO = 8'hF0;
  localparam logic [7:0] FBIO_DIR_RST_HI = 8'hE0;
  localparam logic [7:0] FBIO_DATA_RST = 8'hE0;
  localparam logic [7:0] FBIO_RSVD_MASK = 8'hE0;
  localparam logic [7:0] FBIO_DIR_READ = 8'hFF;
  localparam int FBIO_CS0_PIN = 4;
  localparam int FBIO_REFRESH_STROBE_N_PIN = 0;
  localparam logic [2:0] FBIO_MODE_SINGLE = 3'h7;
  localparam logic [2:0] FBIO_MODE_ROMON = 3'h5;
endpackage : fbio_pkg

//--- hdl/fbio_pin_mux.sv
// fbio_pin_mux: per-pin function selection for the five-pin port.
// assumes registered direction/data values and live function selects.
`timescale 1ns/1ns
module fbio_pin_mux
  import fbio_pkg::*;
(
  input wire logic expanded,
  input wire logic refresh_enable_bit,
  input wire logic refresh_strobe_n,
  input wire logic [3:0] cs_n,
  input wire logic [4:0] dir,
  input wire logic [4:0] data,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n
);
  // chip selects on pins 4..1, refresh on pin 0, else port output
  always_comb begin
    for (int i = 0; i < FBIO_PINS; i++) begin
      pin_out[i] = data[i];
      pin_oe_n[i] = ~dir[i];
    end
    // pin 0 has no chip select, so this loop starts at pin 1 and never indexes past cs_n
    for (int i = 1; i < FBIO_PINS; i++) begin
      if (expanded && dir[i]) begin
        pin_out[i] = cs_n[FBIO_CS0_PIN - i];
      end
    end
    if (refresh_enable_bit) begin
      pin_out[FBIO_REFRESH_STROBE_N_PIN] = refresh_strobe_n;
      pin_oe_n[FBIO_REFRESH_STROBE_N_PIN] = 1'b0;
    end
  end
endmodule : fbio_pin_mux

//--- hdl/fbio_port.sv
// fbio_port: five-pin general io port with direction and data registers.
// assumes a plain register port with one-cycle strobes and synchronous pin inputs.
//
// Summary of operation
// - the port has five two-way pins on bits 4 to 0 of both registers.
// - the direction register is write-only and reads back as all ones.
// - direction bits 7 to 5 ignore writes and read as one.
// - reset or hardware standby loads direction F0 in modes 1-4, E0 in modes 5-7.
// - software standby keeps both registers and keeps output pins driving.
// - the data register drives each pin acting as a port output.
// - data reads return the stored bit where direction is one, else the pin level.
// - reset or hardware standby loads the data register with E0.
// - data bits 7 to 5 ignore writes and read as one.
// - in modes 1-6 direction one on pins 4,3,2,1 drives chip selects 0,1,2,3.
// - in expanded modes pins 4 to 1 with direction zero are inputs.
// - in modes 1-4 only chip select 0 is active after reset.
// - in modes 5 and 6 all four chip-select pins are inputs after reset.
// - refresh enable forces the refresh strobe on pin 0 regardless of direction.
// - in mode 7 every pin is a port by its direction bit, except pin 0 while refresh is enabled.
// - pins 3 to 0 feed interrupt requests 3 to 0 whether input or output.
`timescale 1ns/1ns
module fbio_port
  import fbio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic [2:0] mode,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic refresh_enable_bit,
  input wire logic refresh_strobe_n,
  input wire logic chip_select_zero_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two_n,
  input wire logic chip_select_three_n,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n,
  output logic ext_irq_zero_n,
  output logic ext_irq_one_n,
  output logic ext_irq_two_n,
  output logic ext_irq_three_n
);
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic expanded;
  logic init;
  logic [3:0] cs_n_bus;

  // address decode shared by the write path, the read path and the checks
  // only the lower sixteen bits are compared; wider buses alias above that
  function automatic logic fbio_hits_dir(input logic [15:0] a);
    return (a == FBIO_DIR_ADDR);
  endfunction : fbio_hits_dir

  function automatic logic fbio_hits_data(input logic [15:0] a);
    return (a == FBIO_DATA_ADDR);
  endfunction : fbio_hits_data

  assign expanded = (mode != FBIO_MODE_SINGLE);
  // reset and hardware standby act alike; software standby is simply no write
  assign init = rst | hw_standby;

  // register updates; reserved bits are forced so writes cannot touch them
  always_comb begin
    dir_nxt = dir_r;
    data_nxt = data_r;
    if (init) begin
      // modes 1-4 start with chip select 0 driven, 5-7 all inputs
      dir_nxt = (mode < FBIO_MODE_ROMON) ? FBIO_DIR_RST_LO : FBIO_DIR_RST_HI;
      data_nxt = FBIO_DATA_RST;
    end else if (wr && fbio_hits_dir(addr)) begin
      dir_nxt = wdata | FBIO_RSVD_MASK;
    end else if (wr && fbio_hits_data(addr)) begin
      data_nxt = wdata | FBIO_RSVD_MASK;
    end
  end

  always_ff @(posedge clk) begin
    dir_r <= dir_nxt;
    data_r <= data_nxt;
  end

  // read data, valid the cycle after the strobe only
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd && !init) begin
      if (fbio_hits_dir(addr)) begin
        rdata_nxt = FBIO_DIR_READ;
      end else if (fbio_hits_data(addr)) begin
        // input pins show their level, outputs show the latch
        rdata_nxt = FBIO_RSVD_MASK | (data_r & dir_r) | {3'h0, pin_in & ~dir_r[4:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata_r <= rdata_nxt;
  end
  assign rdata = rdata_r;

  // chip selects gathered with cs0 at index 0, as the mux indexes them
  assign cs_n_bus = {chip_select_three_n, chip_select_two_n,
                     chip_select_one_n, chip_select_zero_n};

  // pin function selection
  fbio_pin_mux u_mux (
    .expanded(expanded),
    .refresh_enable_bit(refresh_enable_bit),
    .refresh_strobe_n(refresh_strobe_n),
    .cs_n(cs_n_bus),
    .dir(dir_r[4:0]),
    .data(data_r[4:0]),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

  // interrupt inputs watch the wire, so a driven pin still raises requests
  assign ext_irq_zero_n = pin_in[0];
  assign ext_irq_one_n = pin_in[1];
  assign ext_irq_two_n = pin_in[2];
  assign ext_irq_three_n = pin_in[3];

  // checks below watch design state only, clocked on clk
  // most stand down while rst is high; the reset-value checks do not
  // hw_standby is never a disable: it is checked as a reset source

  // sequences reused by several assertions below
  sequence s_dir_write;
    wr && !init && fbio_hits_dir(addr);
  endsequence
  sequence s_data_write;
    wr && !init && fbio_hits_data(addr);
  endsequence
  // a write that decodes to neither register must leave both alone
  sequence s_stray_write;
    wr && !init && !fbio_hits_dir(addr) && !fbio_hits_data(addr);
  endsequence
  // single-chip cycle with no write and no refresh steal on pin 0
  sequence s_single_quiet;
    !wr && !init && !expanded && !refresh_enable_bit;
  endsequence
  sequence s_single_port;
    !expanded && !refresh_enable_bit;
  endsequence
  // reset cycles split by the rom setting of the mode
  sequence s_init_rom_off;
    init && mode < FBIO_MODE_ROMON;
  endsequence
  sequence s_init_rom_on;
    init && expanded && mode >= FBIO_MODE_ROMON;
  endsequence

  // direction reads never expose the stored bits
  AST_DIR_READ_ONES: assert property (@(posedge clk) disable iff (rst)
    rd && !hw_standby && fbio_hits_dir(addr) |=> rdata == FBIO_DIR_READ)
    else $error("direction read not all ones");

  // reserved direction bits are forced on every load
  AST_DIR_RSVD: assert property (@(posedge clk) disable iff (rst)
    dir_r[7:5] == 3'h7)
    else $error("direction reserved bits not one");

  // reserved data bits are forced on every load
  AST_DATA_RSVD: assert property (@(posedge clk) disable iff (rst)
    data_r[7:5] == 3'h7)
    else $error("data reserved bits not one");

  // reset value picked by the mode seen in the reset cycle
  AST_DIR_INIT: assert property (@(posedge clk)
    init |=> dir_r == (($past(mode) < FBIO_MODE_ROMON) ? FBIO_DIR_RST_LO : FBIO_DIR_RST_HI))
    else $error("direction reset value wrong");

  // data reset value does not depend on the mode
  AST_DATA_INIT: assert property (@(posedge clk)
    init |=> data_r == FBIO_DATA_RST)
    else $error("data reset value wrong");

  // outputs read back the latch, inputs read back the wire
  AST_DATA_READ: assert property (@(posedge clk) disable iff (rst)
    rd && !hw_standby && fbio_hits_data(addr) |=>
    rdata[4:0] == (($past(data_r[4:0]) & $past(dir_r[4:0])) |
                   ($past(pin_in) & ~$past(dir_r[4:0]))))
    else $error("data read mixes pins wrongly");

  // a data write lands in the live bits the next cycle
  AST_DATA_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_data_write |=> data_r[4:0] == $past(wdata[4:0]))
    else $error("data write not stored");

  // software standby is just the absence of writes: nothing moves
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wr && !hw_standby |=> $stable(dir_r) && $stable(data_r))
    else $error("registers changed without write");

  // single-chip pins follow the two registers directly while refresh is off
  AST_PORT_OUT: assert property (@(posedge clk) disable iff (rst)
    !expanded && !refresh_enable_bit |-> pin_oe_n == ~dir_r[4:0] &&
    pin_out == data_r[4:0])
    else $error("single-chip pin drive wrong");

  // pin 4 carries chip select 0 when its direction bit is set
  AST_CS0: assert property (@(posedge clk) disable iff (rst)
    expanded && dir_r[4] |-> !pin_oe_n[4] && pin_out[4] == chip_select_zero_n)
    else $error("chip select zero not on pin 4");

  // refresh strobe overrides the direction bit on pin 0
  AST_REFRESH_STROBE_N: assert property (@(posedge clk) disable iff (rst)
    refresh_enable_bit |-> !pin_oe_n[0] && pin_out[0] == refresh_strobe_n)
    else $error("refresh strobe not on pin 0");

  // pin 0 without refresh is an ordinary port pin in every mode
  AST_PIN0_PORT: assert property (@(posedge clk) disable iff (rst)
    !refresh_enable_bit |-> pin_oe_n[0] == ~dir_r[0] && pin_out[0] == data_r[0])
    else $error("pin 0 port drive wrong");

  // a direction write keeps the reserved bits set whatever was written
  AST_DIR_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_dir_write |=> dir_r == ($past(wdata) | FBIO_RSVD_MASK))
    else $error("direction write not stored");

  // a data write keeps the reserved bits set as well
  AST_DATA_WRITE_RSVD: assert property (@(posedge clk) disable iff (rst)
    s_data_write |=> data_r == ($past(wdata) | FBIO_RSVD_MASK))
    else $error("data write touched reserved bits");

  // a byte write reaches only the register it selects
  AST_DIR_ONLY: assert property (@(posedge clk) disable iff (rst)
    s_dir_write |=> $stable(data_r))
    else $error("direction write changed data");

  // and the other way round
  AST_DATA_ONLY: assert property (@(posedge clk) disable iff (rst)
    s_data_write |=> $stable(dir_r))
    else $error("data write changed direction");

  // neighbouring addresses such as the input-only port must not alias
  AST_STRAY_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_stray_write |=> $stable(dir_r) && $stable(data_r))
    else $error("unmapped write changed a register");

  // read data stand one cycle only, zero otherwise
  AST_READ_IDLE: assert property (@(posedge clk) disable iff (rst)
    !rd || init |=> rdata == 8'h00)
    else $error("read data not zero when idle");

  // reads outside the two registers return zero
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (rst)
    rd && !fbio_hits_dir(addr) && !fbio_hits_data(addr) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // reserved data bits read as one on every data read
  AST_DATA_READ_RSVD: assert property (@(posedge clk) disable iff (rst)
    rd && !init && fbio_hits_data(addr) |=> rdata[7:5] == 3'h7)
    else $error("data read reserved bits not one");

  // after reset in modes 1-4 only pin 4 drives among the chip-select pins
  AST_RESET_ROM_OFF: assert property (@(posedge clk)
    s_init_rom_off |=> pin_oe_n[4:1] == 4'h7)
    else $error("modes 1-4 reset pin directions wrong");

  // in modes 5 and 6 all four chip-select pins start as inputs
  AST_RESET_ROM_ON: assert property (@(posedge clk)
    s_init_rom_on |=> pin_oe_n[4:1] == 4'hF)
    else $error("modes 5-6 reset pin directions wrong");

  // in single-chip mode pins keep driving while nothing is written
  AST_SINGLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    s_single_quiet ##1 s_single_port |-> $stable(pin_oe_n) && $stable(pin_out))
    else $error("port pins changed without write");

  // single-chip mode never steals pins 4 to 1 for chip selects
  AST_SINGLE_OE: assert property (@(posedge clk) disable iff (rst)
    !expanded |-> pin_oe_n[4:1] == ~dir_r[4:1] && pin_out[4:1] == data_r[4:1])
    else $error("single-chip pins 4 to 1 wrong");

  // request lines mirror the wire whether the pin drives or listens
  AST_IRQ_MIRROR: assert property (@(posedge clk) disable iff (rst)
    {ext_irq_three_n, ext_irq_two_n, ext_irq_one_n, ext_irq_zero_n} == pin_in[3:0])
    else $error("interrupt request does not follow pin");

  // hardware standby alone reinitialises both registers
  // the mode is sampled in the standby cycle, as for reset
  AST_STANDBY_INIT: assert property (@(posedge clk) disable iff (rst)
    hw_standby |=> data_r == FBIO_DATA_RST &&
    dir_r == (($past(mode) < FBIO_MODE_ROMON) ? FBIO_DIR_RST_LO : FBIO_DIR_RST_HI))
    else $error("hardware standby did not reinitialise");

  // per-pin checks of the expanded-mode functions on pins 4 to 1
  for (genvar g = 1; g < FBIO_PINS; g++) begin : g_pin_chk
    // a set direction bit hands the pin to its chip select
    AST_CS_PIN: assert property (@(posedge clk) disable iff (rst)
      expanded && dir_r[g] |-> !pin_oe_n[g] && pin_out[g] == cs_n_bus[FBIO_CS0_PIN - g])
      else $error("chip select pin drive wrong");
    // a clear direction bit leaves the pin listening
    AST_EXP_INPUT: assert property (@(posedge clk) disable iff (rst)
      expanded && !dir_r[g] |-> pin_oe_n[g])
      else $error("expanded input pin driven");
  end
endmodule : fbio_port

//--- testbench/fbio_pins_model.sv
// fbio_pins_model: outside world on the five port pins.
// assumes the port's active-low enables; undriven pins take ext_level.
`timescale 1ns/1ns
module fbio_pins_model (
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  input wire logic [4:0] ext_level,
  output logic [4:0] pin_level
);
  // device wins where it drives, so reads of outputs never see ext_level
  assign pin_level = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule : fbio_pins_model

//--- testbench/five_bit_io_port_chip_select_tb.sv
// five_bit_io_port_chip_select_tb: register and pin checks of fbio_port.
// assumes fbio_pkg and fbio_pins_model; single 100 MHz clock.
`timescale 1ns/1ns
module five_bit_io_port_chip_select_tb;
  import fbio_pkg::*;
  logic clk = 0, rst = 1, hw_standby = 0, wr = 0, rd = 0, rfe = 0, rfs = 1;
  logic [2:0] mode = 3'h7;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [3:0] cs_n = 4'hA, irq_n;
  logic [4:0] ext = 5'h0A, pin_level, pin_out, pin_oe_n;
  int failures = 0, checks = 0;
  fbio_port dut_u (.clk(clk), .rst(rst), .hw_standby(hw_standby), .mode(mode), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .refresh_enable_bit(rfe),
    .refresh_strobe_n(rfs), .chip_select_zero_n(cs_n[0]), .chip_select_one_n(cs_n[1]),
    .chip_select_two_n(cs_n[2]), .chip_select_three_n(cs_n[3]), .pin_in(pin_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_irq_zero_n(irq_n[0]),
    .ext_irq_one_n(irq_n[1]), .ext_irq_two_n(irq_n[2]), .ext_irq_three_n(irq_n[3]));
  fbio_pins_model pins_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
    .pin_level(pin_level));
  always #5 clk = ~clk;
  // shared compare; four-state so an unknown never matches
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    mode <= m;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : do_reset
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #20000;
    failures++;
    stop_test();
  end
  initial begin
    do_reset(3'h7);
    chk("oe_n mode7", 16'h1F, pin_oe_n);
    chk("irq inputs", 16'hA, irq_n);
    rd_reg(FBIO_DIR_ADDR, v);
    chk("dir read", 16'hFF, v);
    rd_reg(FBIO_DATA_ADDR, v);
    chk("data reset", 16'hEA, v);
    wr_reg(FBIO_DIR_ADDR, 8'h0F);
    wr_reg(FBIO_DATA_ADDR, 8'h15);
    wr_reg(16'hFFCE, 8'h00);
    rd_reg(FBIO_DATA_ADDR, v);
    chk("data mixed", 16'hE5, v);
    rd_reg(FBIO_DIR_ADDR, v);
    chk("dir read", 16'hFF, v);
    chk("pins out", 16'h105, {pin_oe_n, pin_out[3:0]});
    chk("irq outputs", 16'h5, irq_n);
    rd_reg(16'hFFCE, v);
    chk("unmapped", 16'h00, v);
    @(posedge clk);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    #1 chk("oe_n standby", 16'h1F, pin_oe_n);
    do_reset(3'h1);
    chk("cs0 only", 16'h0F0, {pin_oe_n, 3'h0, pin_out[4]});
    rd_reg(FBIO_DATA_ADDR, v);
    chk("expanded inputs", 16'hEA, v);
    wr_reg(FBIO_DIR_ADDR, 8'h1E);
    @(posedge clk);
    rfe <= 1'b1;
    rfs <= 1'b0;
    #1 chk("cs and refresh", 16'h00A, {pin_oe_n, pin_out});
    do_reset(3'h5);
    chk("oe_n mode5", 16'h1E, pin_oe_n);
    stop_test();
  end
endmodule : five_bit_io_port_chip_select_tb
